// file: hw/tppg_consts.svh
// Purpose: constants of the timer pulse generator block
// Assumes: byte addresses on an APB bus with 32-bit data
// Notes: definitions only
`ifndef TPPG_CONSTS_SVH
`define TPPG_CONSTS_SVH

// register byte offsets
`define TPPG_OFS_CTRL 8'h00
`define TPPG_OFS_PERIOD 8'h04
`define TPPG_OFS_WIDTH 8'h08
`define TPPG_OFS_COUNT 8'h0C
`define TPPG_OFS_INT_STATUS 8'h10
`define TPPG_OFS_INT_CLEAR 8'h14
`define TPPG_OFS_INT_ENABLE 8'h18
`define TPPG_OFS_CAPTURE 8'h1C

// reset values
`define TPPG_RST_CTRL 8'h00
`define TPPG_RST_DATA 16'h0000
`define TPPG_RST_INT 3'h0

// start condition codes
`define TPPG_START_OFF 2'h0
`define TPPG_START_CMD 2'h1
`define TPPG_START_RISE 2'h2
`define TPPG_START_FALL 2'h3

// mode codes
`define TPPG_MODE_TIMER 2'h0
`define TPPG_MODE_EVENT 2'h1
`define TPPG_MODE_CAPT 2'h2
`define TPPG_MODE_PPG 2'h3

// interrupt status bit positions
`define TPPG_INT_WIDTH 0
`define TPPG_INT_PERIOD 1
`define TPPG_INT_CAPT 2

// source clock prescaler: log2 of each divide ratio of pclk
`define TPPG_DIV_BITS 11
`define TPPG_DIV_SEL0 11
`define TPPG_DIV_SEL1 7
`define TPPG_DIV_SEL2 5
`define TPPG_DIV_SEL3 3

`endif

// file: hw/tppg_pkg.sv
// Purpose: types of the timer pulse generator block
// Assumes: constants come from tppg_consts.svh
// Notes: control word packs like the 8-bit control register
`default_nettype none

package tppg_pkg;

    // bit 7 polarity, bit 6 repeat/capture select, 5:4 start, 3:2 clock, 1:0 mode
    typedef struct packed {
        logic tff;
        logic opt;
        logic [1:0] start;
        logic [1:0] clk_sel;
        logic [1:0] mode;
    } tppg_ctrl_s;

    typedef struct packed {
        logic rise;
        logic fall;
    } tppg_edge_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_RUN
    } tppg_run_e;

endpackage : tppg_pkg

`default_nettype wire

// file: hw/tppg_sync.sv
// Purpose: trigger pin synchroniser and edge detector
// Assumes: pin is asynchronous to pclk
// Notes: edges come in the same pclk cycle that the second stage flop changes
`default_nettype none

module tppg_sync
    import tppg_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pin and edges
    input wire logic pin,
    output tppg_edge_s edge_o
);

    logic meta_q;
    logic sync_q;
    logic last_q;

    // first stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign edge_o.rise = sync_q & ~last_q;
    assign edge_o.fall = ~sync_q & last_q;

endmodule : tppg_sync

`default_nettype wire

// file: hw/tppg_top.sv
// Purpose: 16-bit timer with programmable pulse generation, APB slave
// Assumes: pclk 250 MHz, source clock is a prescaled enable of pclk
// Notes: also timer mode and pulse width capture; event mode idles
`default_nettype none
`include "tppg_consts.svh"

module tppg_top
    import tppg_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins
    input wire logic trigger_input_pin,
    output logic pulse_output_n,
    // interrupts
    output logic timer_interrupt_request,
    output logic irq
);

    tppg_ctrl_s ctrl_q;
    tppg_ctrl_s ctrl_new;
    logic [15:0] period_q;
    logic [15:0] width_q;
    logic [15:0] cap_q;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [15:0] cnt_inc;
    tppg_run_e st_q;
    tppg_run_e st_d;
    logic [`TPPG_DIV_BITS-1:0] div_q;
    logic ff_q;
    logic flipped_q;
    logic pin_q;
    logic [2:0] int_st_q;
    logic [2:0] int_en_q;
    logic [2:0] ev;
    logic irq_q;
    logic tirq_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] rdata;
    tppg_edge_s edge_s;
    logic tick;
    logic start_edge;
    logic stop_edge;
    logic toggle;
    logic auto_stop;
    logic do_cap;
    logic acc;
    logic wr;
    logic rd;

    function automatic logic is_mapped(input logic [7:0] a);
        case (a)
            `TPPG_OFS_CTRL, `TPPG_OFS_PERIOD, `TPPG_OFS_WIDTH,
            `TPPG_OFS_COUNT, `TPPG_OFS_INT_STATUS, `TPPG_OFS_INT_CLEAR,
            `TPPG_OFS_INT_ENABLE, `TPPG_OFS_CAPTURE: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    // all-ones on the low n bits marks one source clock period
    function automatic logic tick_of(input logic [1:0] sel,
                                     input logic [`TPPG_DIV_BITS-1:0] d);
        case (sel)
            2'h0: tick_of = &d[`TPPG_DIV_SEL0-1:0];
            2'h1: tick_of = &d[`TPPG_DIV_SEL1-1:0];
            2'h2: tick_of = &d[`TPPG_DIV_SEL2-1:0];
            default: tick_of = &d[`TPPG_DIV_SEL3-1:0];
        endcase
    endfunction : tick_of

    tppg_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin(trigger_input_pin),
        .edge_o(edge_s)
    );

    // apb: pready one cycle into the access phase, transfer commits then
    assign acc = psel & penable & pready_q;
    assign wr = acc & pwrite & is_mapped(paddr);
    assign rd = psel & penable & ~pready_q & ~pwrite;
    assign ctrl_new = tppg_ctrl_s'(pwdata[7:0]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= psel & penable & ~pready_q;
            pslverr_q <= psel & penable & ~pready_q & ~is_mapped(paddr);
        end
    end

    always_comb begin
        rdata = 32'h0000_0000;
        case (paddr)
            `TPPG_OFS_CTRL: rdata[7:0] = ctrl_q;
            `TPPG_OFS_PERIOD: rdata[15:0] = period_q;
            `TPPG_OFS_WIDTH: rdata[15:0] = width_q;
            `TPPG_OFS_COUNT: rdata[15:0] = cnt_q;
            `TPPG_OFS_INT_STATUS: rdata[2:0] = int_st_q;
            `TPPG_OFS_INT_ENABLE: rdata[2:0] = int_en_q;
            // both capture bytes in one word, so low/high order is moot
            `TPPG_OFS_CAPTURE: rdata[15:0] = cap_q;
            default: rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (rd) begin
            prdata_q <= rdata;
        end
    end

    // control word; one-shot end clears the start field unless written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `TPPG_RST_CTRL;
        end else if (wr && hit(paddr, `TPPG_OFS_CTRL)) begin
            ctrl_q <= ctrl_new;
        end else if (auto_stop) begin
            ctrl_q.start <= `TPPG_START_OFF;
        end
    end

    // compare registers, no shadowing: late small values misfire
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_q <= `TPPG_RST_DATA;
            width_q <= `TPPG_RST_DATA;
        end else begin
            if (wr && hit(paddr, `TPPG_OFS_PERIOD)) begin
                period_q <= pwdata[15:0];
            end
            if (wr && hit(paddr, `TPPG_OFS_WIDTH)) begin
                width_q <= pwdata[15:0];
            end
        end
    end

    // free prescaler gives the source clock enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    assign tick = tick_of(ctrl_q.clk_sel, div_q);
    assign start_edge = (ctrl_q.start == `TPPG_START_RISE) ? edge_s.rise
                                                           : edge_s.fall;
    assign stop_edge = (ctrl_q.start == `TPPG_START_RISE) ? edge_s.fall
                                                          : edge_s.rise;
    assign cnt_inc = cnt_q + 16'h0001;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        ev = 3'h0;
        toggle = 1'b0;
        auto_stop = 1'b0;
        do_cap = 1'b0;
        if (ctrl_q.start == `TPPG_START_OFF) begin
            st_d = ST_IDLE;
            cnt_d = 16'h0000;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    cnt_d = 16'h0000;
                    if (ctrl_q.start == `TPPG_START_CMD) begin
                        st_d = ST_RUN;
                    end else begin
                        st_d = ST_ARMED;
                    end
                end
                ST_ARMED: begin
                    if (start_edge) begin
                        st_d = ST_RUN;
                        cnt_d = 16'h0000;
                    end
                end
                ST_RUN: begin
                    case (ctrl_q.mode)
                        `TPPG_MODE_PPG: begin
                            if (tick) begin
                                cnt_d = cnt_inc;
                                if (cnt_inc == period_q) begin
                                    ev[`TPPG_INT_PERIOD] = 1'b1;
                                    toggle = 1'b1;
                                    cnt_d = 16'h0000;
                                    if (ctrl_q.opt) begin
                                        auto_stop = 1'b1;
                                        st_d = ST_IDLE;
                                    end
                                end else if (cnt_inc == width_q) begin
                                    ev[`TPPG_INT_WIDTH] = 1'b1;
                                    toggle = 1'b1;
                                end
                            end
                        end
                        `TPPG_MODE_TIMER: begin
                            if (tick) begin
                                cnt_d = cnt_inc;
                                if (cnt_inc == period_q) begin
                                    ev[`TPPG_INT_PERIOD] = 1'b1;
                                    cnt_d = 16'h0000;
                                end
                            end
                        end
                        `TPPG_MODE_CAPT: begin
                            if (stop_edge) begin
                                ev[`TPPG_INT_CAPT] = 1'b1;
                                do_cap = 1'b1;
                                if (ctrl_q.opt) begin
                                    cnt_d = 16'h0000;
                                    st_d = ST_ARMED;
                                end
                            end else if (start_edge && !ctrl_q.opt) begin
                                ev[`TPPG_INT_CAPT] = 1'b1;
                                do_cap = 1'b1;
                                cnt_d = 16'h0000;
                            end else if (tick) begin
                                cnt_d = cnt_inc;
                            end
                        end
                        default: begin
                            st_d = ST_IDLE;
                        end
                    endcase
                end
                default: begin
                    st_d = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ST_IDLE;
            cnt_q <= `TPPG_RST_DATA;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
        end
    end

    // capture is overwritten on each do_cap; unread values are lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_q <= `TPPG_RST_DATA;
        end else if (do_cap) begin
            cap_q <= cnt_q;
        end
    end

    // output flip-flop; flipped_q remembers an odd number of inversions
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ff_q <= 1'b0;
            flipped_q <= 1'b0;
        end else if (toggle) begin
            ff_q <= ~ff_q;
            flipped_q <= ~flipped_q;
        end else if (wr && hit(paddr, `TPPG_OFS_CTRL) &&
                     ctrl_new.mode == `TPPG_MODE_PPG) begin
            if (ctrl_q.mode != `TPPG_MODE_PPG) begin
                ff_q <= ctrl_new.tff;
                flipped_q <= 1'b0;
            end else if (ctrl_q.start == `TPPG_START_OFF) begin
                // polarity written mid-run is ignored
                ff_q <= ctrl_new.tff ^ flipped_q;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q <= 1'b1;
        end else begin
            pin_q <= ~ff_q;
        end
    end

    // sticky status: a new event beats a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_st_q <= `TPPG_RST_INT;
            int_en_q <= `TPPG_RST_INT;
        end else begin
            if (wr && hit(paddr, `TPPG_OFS_INT_CLEAR)) begin
                int_st_q <= (int_st_q & ~pwdata[2:0]) | ev;
            end else begin
                int_st_q <= int_st_q | ev;
            end
            if (wr && hit(paddr, `TPPG_OFS_INT_ENABLE)) begin
                int_en_q <= pwdata[2:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
            tirq_q <= 1'b0;
        end else begin
            irq_q <= |(int_st_q & int_en_q);
            tirq_q <= |ev;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign pulse_output_n = pin_q;
    assign timer_interrupt_request = tirq_q;
    assign irq = irq_q;

endmodule : tppg_top

`default_nettype wire

// file: tb/tppg_assertions.sv
// Purpose: port checker of the timer pulse generator
// Assumes: control and enable writes are seen on the apb ports
// Notes: bound into tppg_top
`default_nettype none
`include "tppg_consts.svh"

module tppg_checker
    import tppg_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins
    input wire logic trigger_input_pin,
    input wire logic pulse_output_n,
    input wire logic timer_interrupt_request,
    input wire logic irq
);
    tppg_ctrl_s ctrl_q;
    logic [1:0] ien_q;
    logic [2:0] age_q;
    logic [2:0] tirs_q;
    logic wr_done;
    logic ctrl_wr;
    logic ppg;
    logic tir;

    assign tir = timer_interrupt_request;
    assign wr_done = psel && penable && pready && pwrite;
    assign ctrl_wr = wr_done && paddr == `TPPG_OFS_CTRL;
    assign ppg = ctrl_q.mode == `TPPG_MODE_PPG;

    // snooped copy misses the one-shot auto stop; that only narrows checks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= '0;
            ien_q <= 2'h0;
        end else if (ctrl_wr) begin
            ctrl_q <= pwdata[7:0];
        end else if (wr_done && paddr == `TPPG_OFS_INT_ENABLE) begin
            ien_q <= pwdata[1:0];
        end
    end

    // cycles and requests since the last control write, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age_q <= 3'h0;
            tirs_q <= 3'h0;
        end else if (ctrl_wr) begin
            age_q <= 3'h0;
            tirs_q <= 3'h0;
        end else begin
            age_q <= age_q + 3'(age_q != 3'h7);
            tirs_q <= tirs_q + 3'(tir && tirs_q != 3'h7);
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_wait;
        psel && penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence

    a_apb_one_wait:
        assert property ($rose(penable) && psel |-> s_wait ##1 s_answer)
        else $error("apb answer off its slot");
    a_err_with_ready:
        assert property (pslverr |-> pready)
        else $error("error flag without ready");
    a_tir_one_cycle:
        assert property (tir |=> !tir)
        else $error("request longer than one cycle");
    // pin follows the request by one cycle: both launch from the same toggle
    a_match_toggles:
        assert property (tir && ppg |=> $changed(pulse_output_n))
        else $error("match without pin toggle");
    a_toggle_cause:
        assert property ($changed(pulse_output_n) && age_q > 3'h1
            |-> $past(tir))
        else $error("pin changed without a match");
    a_stop_quiet:
        assert property (ctrl_q.start == `TPPG_START_OFF && age_q > 3'h1
            |-> !tir)
        else $error("request while stopped");
    a_oneshot_halt:
        assert property (ctrl_q.opt && ppg |-> tirs_q < 3'h3)
        else $error("one-shot ran past its period");
    a_irq_follows:
        assert property (tir && ppg && ien_q == 2'h3 |=> irq)
        else $error("irq missing after enabled match");
    a_reset_quiet:
        assert property ($rose(presetn) |-> pulse_output_n && !tir && !irq)
        else $error("outputs wrong after reset");
endmodule : tppg_checker

bind tppg_top tppg_checker i_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .trigger_input_pin, .pulse_output_n, .timer_interrupt_request, .irq);

`default_nettype wire

// file: tb/tppg_link_model.sv
// Purpose: trigger source and pulse load beside the timer block
// Assumes: trigger is a plain level held between edges
// Notes: reports spacing of pulse pin changes in pclk cycles
`default_nettype none

module tppg_link_model (
    // clock
    input wire logic pclk,
    // pins
    output logic trig,
    input wire logic pin_n,
    // spacing and count of pin changes
    output int gap_q,
    output int flips_q
);
    logic pin_q = 1'b1;
    int cnt_q;

    initial trig = 1'b0;

    // one edge per call, launched just after a clock edge
    task automatic flip_trig();
        @(posedge pclk);
        trig <= ~trig;
    endtask : flip_trig

    always @(posedge pclk) begin
        pin_q <= pin_n;
        cnt_q <= cnt_q + 1;
        if (pin_n !== pin_q) begin
            gap_q <= cnt_q;
            cnt_q <= 1;
            flips_q <= flips_q + 1;
        end
    end
endmodule : tppg_link_model

`default_nettype wire

// file: tb/timer_pulse_generator_ppg_tb_top.sv
// Purpose: self-checking bench of the timer pulse generator
// Assumes: every control word selects the pclk/8 source clock
// Notes: random period and width from a fixed seed
`default_nettype none
`include "tppg_consts.svh"

module timer_pulse_generator_ppg_tb_top
    import tppg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic pclk, presetn, psel, penable, pwrite, trig;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, pulse_output_n, tir, irq, err, pin0;
    int errors, num_checks, gap, flips, w, p, f, cyc, c0;

    tppg_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .trigger_input_pin(trig),
        .pulse_output_n, .timer_interrupt_request(tir), .irq);
    tppg_link_model i_link (.pclk, .trig, .pin_n(pulse_output_n),
        .gap_q(gap), .flips_q(flips));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // edge count, so trigger spacing does not depend on bus latency
    always @(posedge pclk) begin
        cyc <= cyc + 1;
    end

    function automatic int exp_gap(input int ticks);
        return ticks << `TPPG_DIV_SEL3;
    endfunction : exp_gap

    task automatic check(input string what, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    task automatic apb(input logic wr_en, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr_en;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 40) begin
            errors++;
            close_out();
        end
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic ctl(input logic pol, opt, input logic [1:0] st, md);
        wr(`TPPG_OFS_CTRL, {24'h00_0000, pol, opt, st, 2'b11, md});
    endtask : ctl

    task automatic wait_flips(input int n);
        int t;
        t = 0;
        while (flips < n && t < 20000) begin
            @(posedge pclk);
            t++;
        end
        if (t >= 20000) begin
            errors++;
            close_out();
        end
    endtask : wait_flips

    task automatic cycles(input int n);
        repeat (n) @(posedge pclk);
    endtask : cycles

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        void'($urandom(46));
        cycles(2);
        presetn <= 1'b1;
        check("reset pin", 32'(pulse_output_n), 1);
        apb(1'b0, `TPPG_OFS_CTRL, 32'h0000_0000);
        check("reset ctrl", rd, 32'h0000_0000);
        apb(1'b0, 8'h20, 32'h0000_0000);
        check("unmapped", 32'(err), 1);
        $display("test reset done");
        for (int k = 0; k < 3; k++) begin
            w = 2 + $urandom % 6;
            p = (k == 0) ? w + 1 : w + 2 + $urandom % 6;
            ctl(1'b0, 1'b0, `TPPG_START_OFF, `TPPG_MODE_TIMER);
            ctl(k[0], 1'b0, `TPPG_START_OFF, `TPPG_MODE_PPG);
            cycles(2);
            check("start level", 32'(pulse_output_n),
                32'(!k[0]));
            wr(`TPPG_OFS_PERIOD, 32'(p));
            wr(`TPPG_OFS_WIDTH, 32'(w));
            wr(`TPPG_OFS_INT_ENABLE, 32'h0000_0003);
            f = flips;
            ctl(k[0], 1'b0, `TPPG_START_CMD, `TPPG_MODE_PPG);
            wait_flips(f + 2);
            check("period gap", 32'(gap),
                32'(exp_gap(p - w)));
            wait_flips(f + 3);
            check("width gap", 32'(gap), 32'(exp_gap(w)));
            check("irq", 32'(irq), 1);
            apb(1'b0, `TPPG_OFS_INT_STATUS, 32'h0000_0000);
            check("status", rd, 32'h0000_0003);
            ctl(k[0], 1'b0, `TPPG_START_OFF, `TPPG_MODE_PPG);
            cycles(3);
            pin0 = pulse_output_n;
            f = flips;
            cycles(16 * p);
            check("held", 32'(pulse_output_n), 32'(pin0));
            check("stopped", 32'(flips), 32'(f));
            wr(`TPPG_OFS_INT_CLEAR, 32'h0000_0007);
            cycles(3);
            check("irq cleared", 32'(irq), 0);
        end
        $display("test continuous done");
        for (int s = 0; s < 2; s++) begin
            ctl(1'b0, 1'b0, `TPPG_START_OFF, `TPPG_MODE_TIMER);
            ctl(1'b1, 1'b1, `TPPG_START_OFF, `TPPG_MODE_PPG);
            wr(`TPPG_OFS_INT_ENABLE, 32'h0000_0000);
            f = flips;
            ctl(1'b1, 1'b1, s ? `TPPG_START_FALL : `TPPG_START_RISE,
                `TPPG_MODE_PPG);
            cycles(64);
            check("armed", 32'(flips), 32'(f));
            i_link.flip_trig();
            wait_flips(f + 2);
            cycles(16 * p);
            check("one shot", 32'(flips), 32'(f + 2));
            check("end level", 32'(pulse_output_n), 0);
            apb(1'b0, `TPPG_OFS_CTRL, 32'h0000_0000);
            check("auto stop", 32'(rd[5:4]),
                32'(`TPPG_START_OFF));
            check("masked", 32'(irq), 0);
            wr(`TPPG_OFS_INT_ENABLE, 32'h0000_0003);
            cycles(3);
            check("unmasked", 32'(irq), 1);
            wr(`TPPG_OFS_INT_CLEAR, 32'h0000_0003);
            cycles(3);
            check("cleared", 32'(irq), 0);
        end
        $display("test one-shot done");
        // double capture: edges spaced 8n+1 edges give exactly n ticks
        ctl(1'b0, 1'b0, `TPPG_START_RISE, `TPPG_MODE_CAPT);
        cycles(4);
        i_link.flip_trig();
        cycles(8 * w);
        i_link.flip_trig();
        c0 = cyc;
        cycles(8);
        apb(1'b0, `TPPG_OFS_CAPTURE, 32'h0000_0000);
        check("high width", rd, 32'(w));
        cycles(8 * p - (cyc - c0));
        i_link.flip_trig();
        cycles(8);
        apb(1'b0, `TPPG_OFS_CAPTURE, 32'h0000_0000);
        check("full cycle", rd, 32'(w + p));
        apb(1'b0, `TPPG_OFS_INT_STATUS, 32'h0000_0000);
        check("capt status", rd, 32'h0000_0004);
        ctl(1'b0, 1'b0, `TPPG_START_OFF, `TPPG_MODE_CAPT);
        $display("test capture done");
        close_out();
    end
endmodule : timer_pulse_generator_ppg_tb_top

`default_nettype wire
